// File: logic/nco_top.sv
// Quadrature oscillator with optional output scaling and an output buffer.
// Assumes all control inputs come from logic on core_clk_i, so none is synchronised.
`timescale 1ns/100ps
`include "nco_map.svh"

module nco_top
  import nco_pkg::*;
  (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Input word and its load strobe.
  input wire logic [`NCO_ACC_W-1:0] phase_word_i,
  input wire logic input_load_enable_n_i,
  // Mode selects.
  input wire logic multiplier_select_i,
  input wire logic phase_load_select_i,
  input wire logic accum_clear_i,
  // Valid flag beside the data.
  input wire logic valid_in_flag_i,
  // Drive enables for the two sample buses.
  input wire logic quad_drive_enable_n_i,
  input wire logic inphase_drive_enable_n_i,
  // Sample outputs.
  output nco_sample_t quad_wave_o,
  output nco_sample_t inphase_wave_o,
  output logic quad_wave_oe_n_o,
  output logic inphase_wave_oe_n_o,
  output logic valid_out_flag_o,
  // Buffer handshake.
  input wire logic sample_ready_i,
  output logic buffer_ready_o
  );

  logic [`NCO_ACC_W-1:0] in_q; // Input register.
  logic jump_q; // Phase load select, aligned to the input register.
  logic mode_q; // Multiplier select, aligned to the input register.
  logic clr_q; // Clear request, aligned to the input register.
  logic [`NCO_ACC_W-1:0] acc_q; // Phase accumulator.
  logic [`NCO_ACC_W-1:0] inc_q; // Phase increment register.
  logic [`NCO_ACC_W-1:0] inc_d; // Increment in force for this step.
  nco_act_e act; // Action of the accumulator stage.
  logic [16:0] scl_q [0:`NCO_SC_LAT]; // Scale enable and value beside the generator.
  logic [`NCO_VPIPE_LEN-1:0] vpipe_q; // Valid flag delay line.
  nco_sample_t sin_raw; // Generator sine.
  nco_sample_t cos_raw; // Generator cosine.
  nco_sample_t quad_q; // Sine after the scaler.
  nco_sample_t inph_q; // Cosine after the scaler.
  logic [31:0] buf_out; // Buffer head, sine in the upper half.
  logic scl_on; // Scaling enabled for the samples now at the scaler.
  nco_sample_t scl_val; // Scale for the samples now at the scaler.

  // Input register: loads while the strobe is low, otherwise holds.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      in_q <= '0;
    else if (!input_load_enable_n_i)
      in_q <= phase_word_i;
  end

  // Selects are registered so they meet the word they belong with.
  // The source is expected to pulse the load enable with the jump select.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      jump_q <= 1'b0;
      mode_q <= 1'b0;
      clr_q <= 1'b0;
    end
    else
    begin
      jump_q <= phase_load_select_i;
      mode_q <= multiplier_select_i;
      clr_q <= accum_clear_i;
    end
  end

  // Decode of the four load modes; clear overrides all of them.
  always_comb
  begin
    if (clr_q)
      act = NCO_ACT_CLEAR;
    else if (!mode_q && !jump_q)
      act = NCO_ACT_FM;
    else if (!mode_q)
      act = NCO_ACT_JUMP;
    else if (!jump_q)
      act = NCO_ACT_AM;
    else
      act = NCO_ACT_FULL;
  end

  // Increment in force this cycle, so a new value steers the very next step.
  always_comb
  begin
    case (act)
      // Whole word is the increment; a new one may come every cycle.
      NCO_ACT_FM: inc_d = in_q;
      // Jump leaves the increment alone.
      NCO_ACT_JUMP: inc_d = inc_q;
      // Only the low field is taken; the upper bits stay as loaded before.
      NCO_ACT_AM: inc_d = {inc_q[`NCO_ACC_W-1:`NCO_INC_MSB+1],
        in_q[`NCO_INC_MSB:`NCO_INC_LSB]};
      // All bits of the increment are replaced.
      NCO_ACT_FULL: inc_d = in_q;
      // Clear zeroes the increment.
      NCO_ACT_CLEAR: inc_d = '0;
      default: inc_d = inc_q;
    endcase
  end

  // Increment register.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      inc_q <= '0;
    else
      inc_q <= inc_d;
  end

  // Accumulator: the add drops its carry, so the phase wraps.
  // Earlier phases are already in the generator, so a jump or clear
  // only changes samples that follow it.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      acc_q <= '0;
    else
    begin
      case (act)
        NCO_ACT_JUMP: acc_q <= in_q;
        NCO_ACT_CLEAR: acc_q <= '0;
        default: acc_q <= acc_q + inc_d;
      endcase
    end
  end

  // Generator addressed by the top accumulator bits.
  nco_sincos u_sincos (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .phase_i(acc_q[`NCO_ACC_W-1:`NCO_ACC_W-`NCO_PH_W]),
    .sin_o(sin_raw),
    .cos_o(cos_raw)
  );

  // The scale travels beside its phase, so amplitude and phase stay paired.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i <= `NCO_SC_LAT; i++)
        scl_q[i] <= '0;
    end
    else
    begin
      scl_q[0] <= {mode_q, in_q[`NCO_SCL_MSB:`NCO_SCL_LSB]};
      for (int i = 1; i <= `NCO_SC_LAT; i++)
        scl_q[i] <= scl_q[i-1];
    end
  end

  assign scl_on = scl_q[`NCO_SC_LAT][16];
  assign scl_val = scl_q[`NCO_SC_LAT][15:0];

  // Fraction times fraction, rounded to nearest; the lone overflow case clips.
  function automatic nco_sample_t scale(input nco_sample_t a, input nco_sample_t b);
    logic signed [31:0] p;
    logic signed [31:0] r;
    p = a * b;
    r = p + 32'sh00004000;
    if (r[31:30] == 2'b01)
      scale = 16'sh7FFF;
    else
      scale = r[30:15];
  endfunction

  // Output multipliers, bypassed when scaling is off.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      quad_q <= '0;
      inph_q <= '0;
    end
    else if (scl_on)
    begin
      quad_q <= scale(sin_raw, scl_val);
      inph_q <= scale(cos_raw, scl_val);
    end
    else
    begin
      quad_q <= sin_raw;
      inph_q <= cos_raw;
    end
  end

  // Valid flag rides a plain delay line and steers nothing but the buffer.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      vpipe_q <= '0;
    else
      vpipe_q <= {vpipe_q[`NCO_VPIPE_LEN-2:0], valid_in_flag_i};
  end

  // Output buffer: a stalled sink lets it fill, and its ready goes to the source.
  nco_fifo #(.W(32), .DEPTH(`NCO_FIFO_DEPTH)) u_fifo (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .in_valid_i(vpipe_q[`NCO_VPIPE_LEN-1]),
    .in_data_i({quad_q, inph_q}),
    .in_ready_o(buffer_ready_o),
    .out_valid_o(valid_out_flag_o),
    .out_data_o(buf_out),
    .out_ready_i(sample_ready_i)
  );

  // Sine on the quadrature bus, cosine on the in-phase bus.
  assign quad_wave_o = buf_out[31:16];
  assign inphase_wave_o = buf_out[15:0];
  // Enables are passed through; the pads are outside this block.
  assign quad_wave_oe_n_o = quad_drive_enable_n_i;
  assign inphase_wave_oe_n_o = inphase_drive_enable_n_i;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // A valid input on a cycle when the buffer reports ready.
  sequence s_valid_in;
    valid_in_flag_i && buffer_ready_o;
  endsequence

  sequence s_valid_out;
    ##31 valid_out_flag_o;
  endsequence

  a_input_load: assert property (!input_load_enable_n_i |=> in_q == $past(phase_word_i))
    else $error("Input word not captured.");
  a_input_hold: assert property (input_load_enable_n_i |=> $stable(in_q))
    else $error("Input register changed without load.");
  a_fm_accum: assert property ((act == NCO_ACT_FM) |=>
    acc_q == $past(acc_q) + $past(in_q) && inc_q == $past(in_q))
    else $error("Increment mode step wrong.");
  a_jump_phase: assert property ((act == NCO_ACT_JUMP) |=>
    acc_q == $past(in_q) && $stable(inc_q))
    else $error("Absolute phase not loaded.");
  a_am_increment: assert property ((act == NCO_ACT_AM) |=>
    inc_q[17:0] == $past(in_q[17:0]) && $stable(inc_q[33:18]))
    else $error("Short increment load wrong.");
  a_full_increment: assert property ((act == NCO_ACT_FULL) |=> inc_q == $past(in_q))
    else $error("Full increment not loaded.");
  a_clear_zeroes: assert property (accum_clear_i |=> ##1 (acc_q == '0 && inc_q == '0))
    else $error("Clear did not zero accumulator and increment.");
  a_jump_delayed: assert property ((phase_load_select_i && !multiplier_select_i
    && !accum_clear_i) |=> ##1 acc_q == $past(in_q))
    else $error("Jump not applied one register later.");
  a_unscaled_path: assert property (!scl_on |=> quad_q == $past(sin_raw)
    && inph_q == $past(cos_raw))
    else $error("Unscaled samples altered.");
  a_valid_latency: assert property (s_valid_in |-> s_valid_out)
    else $error("Valid result not seen 31 cycles after input.");

endmodule

// File: logic/nco_map.svh
// Constants for the quadrature oscillator: widths, field positions, latencies.
// Assumes it is included by its bare name from every file that needs a figure.
`ifndef NCO_MAP_SVH
`define NCO_MAP_SVH

// Width of the phase accumulator and of the input word.
`define NCO_ACC_W 34
// Width of the phase fed to the sine and cosine generator.
`define NCO_PH_W 16
// Width of one output sample.
`define NCO_SMP_W 16
// Field of the input word that carries the scale value.
`define NCO_SCL_MSB 33
`define NCO_SCL_LSB 18
// Field of the input word that carries the short phase increment.
`define NCO_INC_MSB 17
`define NCO_INC_LSB 0
// Number of rotation stages in the sine and cosine generator.
`define NCO_CORDIC_STG 16
// Extra delay stages after the rotation stages of the generator.
`define NCO_SC_PAD 10
// Total latency of the sine and cosine generator in cycles.
`define NCO_SC_LAT 27
// Cycles from the input edge to a visible valid result.
`define NCO_RESULT_LAT 31
// Length of the valid flag delay line up to the buffer.
`define NCO_VPIPE_LEN 30
// Starting length of the rotation vector, about 0.607 of full scale.
`define NCO_CORDIC_X0 18'h04DBA
// Half a turn in phase units, used to fold the left half plane.
`define NCO_HALF_TURN 16'h8000
// Depth of the output sample buffer.
`define NCO_FIFO_DEPTH 8

`endif

// File: logic/nco_pkg.sv
// Types shared by the quadrature oscillator modules.
// Assumes nco_map.svh is available on the include path.
`include "nco_map.svh"

package nco_pkg;

  // One signed output sample in fractional format.
  typedef logic signed [`NCO_SMP_W-1:0] nco_sample_t;

  // Action taken by the accumulator stage on one cycle, one-hot.
  typedef enum logic [4:0] {
    NCO_ACT_FM    = 5'h01,
    NCO_ACT_JUMP  = 5'h02,
    NCO_ACT_AM    = 5'h04,
    NCO_ACT_FULL  = 5'h08,
    NCO_ACT_CLEAR = 5'h10
  } nco_act_e;

endpackage

// File: logic/nco_fifo.sv
// Small first-word-fall-through buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active high reset.
`timescale 1ns/100ps

module nco_fifo
  #(parameter int W = 32,
    parameter int DEPTH = 8)
  (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Filling side.
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  // Draining side.
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
  );

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem_q [0:DEPTH-1]; // Storage words.
  logic [PW-1:0] wr_q; // Next slot to fill.
  logic [PW-1:0] rd_q; // Oldest slot.
  logic [CW-1:0] cnt_q; // Words held.
  logic push; // Word accepted this cycle.
  logic pop; // Word drained this cycle.

  // Full and empty come straight from the count, so they never lie.
  assign in_ready_o = (cnt_q != CW'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Pointer step with an explicit wrap, so a depth that is not a power of two works.
  function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
    step = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Storage is cleared at reset so that the data outputs are never unknown.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= '0;
    end
    else if (push)
      mem_q[wr_q] <= in_data_i;
  end

  // Pointers and count.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= step(wr_q);
      if (pop)
        rd_q <= step(rd_q);
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end

  // A push into a full buffer must be refused, so the count never passes the depth.
  a_fifo_no_overrun: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (cnt_q == CW'(DEPTH)) && !out_ready_i |=> (cnt_q == CW'(DEPTH)))
    else $error("Buffer count moved past full.");

endmodule

// File: logic/nco_sincos.sv
// Pipelined rotation generator: a 16-bit phase in, sine and cosine out.
// Assumes one clock and a synchronous active high reset; latency is fixed.
`timescale 1ns/100ps
`include "nco_map.svh"

module nco_sincos
  import nco_pkg::*;
  (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Phase in, one full turn spans the whole code range.
  input wire logic [`NCO_PH_W-1:0] phase_i,
  // Samples out.
  output nco_sample_t sin_o,
  output nco_sample_t cos_o
  );

  logic signed [17:0] x_q [0:`NCO_CORDIC_STG]; // Cosine path of each stage.
  logic signed [17:0] y_q [0:`NCO_CORDIC_STG]; // Sine path of each stage.
  logic signed [15:0] z_q [0:`NCO_CORDIC_STG]; // Residual angle of each stage.
  nco_sample_t sin_q [0:`NCO_SC_PAD-1]; // Padding delay for the sine.
  nco_sample_t cos_q [0:`NCO_SC_PAD-1]; // Padding delay for the cosine.
  logic fold; // Phase lies in the left half plane.

  assign fold = phase_i[15] ^ phase_i[14];

  // Arc tangent of two to the minus i, in phase units.
  function automatic logic signed [15:0] atan(input logic [3:0] i);
    case (i)
      4'h0: atan = 16'h2000;
      4'h1: atan = 16'h12E4;
      4'h2: atan = 16'h09FB;
      4'h3: atan = 16'h0511;
      4'h4: atan = 16'h028B;
      4'h5: atan = 16'h0146;
      4'h6: atan = 16'h00A3;
      4'h7: atan = 16'h0051;
      4'h8: atan = 16'h0029;
      4'h9: atan = 16'h0014;
      4'hA: atan = 16'h000A;
      4'hB: atan = 16'h0005;
      4'hC: atan = 16'h0003;
      4'hD: atan = 16'h0001;
      4'hE: atan = 16'h0001;
      default: atan = 16'h0000;
    endcase
  endfunction

  // The gain lands slightly above full scale at the peaks, so clip rather than wrap.
  function automatic nco_sample_t sat(input logic signed [17:0] v);
    if (v > 18'sh07FFF)
      sat = 16'sh7FFF;
    else if (v < -18'sh08000)
      sat = 16'sh8000;
    else
      sat = v[15:0];
  endfunction

  // Fold, rotate and pad: every sample sees the same number of stages.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i <= `NCO_CORDIC_STG; i++)
      begin
        x_q[i] <= '0;
        y_q[i] <= '0;
        z_q[i] <= '0;
      end
      for (int k = 0; k < `NCO_SC_PAD; k++)
      begin
        sin_q[k] <= '0;
        cos_q[k] <= '0;
      end
    end
    else
    begin
      // A half turn fold keeps the rotation inside its convergence range.
      x_q[0] <= fold ? -$signed(`NCO_CORDIC_X0) : $signed(`NCO_CORDIC_X0);
      y_q[0] <= '0;
      z_q[0] <= fold ? phase_i - `NCO_HALF_TURN : phase_i;
      for (int i = 0; i < `NCO_CORDIC_STG; i++)
      begin
        if (z_q[i][15])
        begin
          x_q[i+1] <= x_q[i] + (y_q[i] >>> i);
          y_q[i+1] <= y_q[i] - (x_q[i] >>> i);
          z_q[i+1] <= z_q[i] + atan(4'(i));
        end
        else
        begin
          x_q[i+1] <= x_q[i] - (y_q[i] >>> i);
          y_q[i+1] <= y_q[i] + (x_q[i] >>> i);
          z_q[i+1] <= z_q[i] - atan(4'(i));
        end
      end
      // Both waveforms leave the same stage together.
      sin_q[0] <= sat(y_q[`NCO_CORDIC_STG]);
      cos_q[0] <= sat(x_q[`NCO_CORDIC_STG]);
      for (int k = 1; k < `NCO_SC_PAD; k++)
      begin
        sin_q[k] <= sin_q[k-1];
        cos_q[k] <= cos_q[k-1];
      end
    end
  end

  assign sin_o = sin_q[`NCO_SC_PAD-1];
  assign cos_o = cos_q[`NCO_SC_PAD-1];

  a_zero_phase_out: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (phase_i == '0) |-> ##27 ((cos_o > 16'sh7F00) && (sin_o < 16'sh0010)
      && (sin_o > -16'sh0010)))
    else $error("Zero phase did not give full cosine and null sine.");

endmodule

// File: bench/nco_src.sv
// Upstream source model: drives the input word, its load strobe and the mode selects.
// Assumes the bench calls its tasks and that every pin changes just after a rising edge.
`timescale 1ns/100ps
`include "nco_map.svh"

module nco_src
  (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Word, strobe and selects toward the oscillator.
  output logic [`NCO_ACC_W-1:0] phase_word_o,
  output logic load_en_n_o,
  output logic mode_o,
  output logic jump_o,
  output logic clear_o,
  output logic valid_o
  );

  // Quiet levels at time zero, so nothing unknown reaches the oscillator.
  initial
  begin
    phase_word_o = '0;
    load_en_n_o = 1'b1;
    mode_o = 1'b0;
    jump_o = 1'b0;
    clear_o = 1'b0;
    valid_o = 1'b0;
  end

  // One word per cycle; the strobe is forced low with any jump so its word is caught.
  task automatic send(input logic [`NCO_ACC_W-1:0] w, input logic ld_n, input logic m,
                      input logic j, input logic c, input logic v);
    @(posedge core_clk_i);
    phase_word_o <= w;
    load_en_n_o <= ld_n & ~j;
    mode_o <= m;
    jump_o <= j;
    clear_o <= c;
    valid_o <= v;
  endtask

  // Released word: it flips every cycle, since a stale value would hide a missed hold.
  task automatic idle();
    @(posedge core_clk_i);
    phase_word_o <= ~phase_word_o;
    load_en_n_o <= 1'b1;
    mode_o <= 1'b0;
    jump_o <= 1'b0;
    clear_o <= 1'b0;
    valid_o <= 1'b0;
  endtask

endmodule

// File: bench/tb.sv
// Self-checking bench for the quadrature oscillator with its output buffer.
// Assumes the source model drives the word, strobe, selects and valid, and a monitor here takes popped samples.
`timescale 1ns/100ps
`include "nco_map.svh"

module tb
  import nco_pkg::*;
  ;

  // Clock, reset and design pins.
  logic core_clk_i;
  logic rst_i;
  logic [`NCO_ACC_W-1:0] word;
  logic ld_n;
  logic mode;
  logic jump;
  logic clr;
  logic valid_in_flag;
  logic sample_ready;
  logic buf_ready;
  logic oes_n; // Drive enable for the sine bus, toggled by the bench.
  logic oec_n; // Drive enable for the cosine bus, toggled by the bench.
  logic oes_seen; // Sine bus drive enable as the design passes it out.
  logic oec_seen; // Cosine bus drive enable as the design passes it out.
  logic valid_out_flag;
  nco_sample_t quad;
  nco_sample_t inph;
  // Popped samples with their pop times.
  nco_sample_t q_sin[$];
  nco_sample_t q_cos[$];
  longint q_t[$];
  int n_mismatch = 0;
  int cmp_count = 0;
  longint t_in;
  longint t_pop;
  // Expected sample levels; the generator is approximate, so checks allow a few codes.
  localparam nco_sample_t P = 16'sh7FFF;
  localparam nco_sample_t N = 16'sh8001;
  localparam nco_sample_t Z = 16'sh0000;
  localparam nco_sample_t H = 16'sh4000;
  localparam nco_sample_t HN = 16'shC000;
  localparam logic [`NCO_ACC_W-1:0] Q = 34'h100000000;

  initial
  begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  nco_src nco_src_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .phase_word_o(word),
    .load_en_n_o(ld_n), .mode_o(mode), .jump_o(jump), .clear_o(clr), .valid_o(valid_in_flag));

  // Drive enables come from the bench so both pass-through paths are checked.
  nco_top nco_top_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .phase_word_i(word),
    .input_load_enable_n_i(ld_n), .multiplier_select_i(mode), .phase_load_select_i(jump),
    .accum_clear_i(clr), .valid_in_flag_i(valid_in_flag), .quad_drive_enable_n_i(oes_n),
    .inphase_drive_enable_n_i(oec_n), .quad_wave_o(quad), .inphase_wave_o(inph),
    .quad_wave_oe_n_o(oes_seen), .inphase_wave_oe_n_o(oec_seen), .valid_out_flag_o(valid_out_flag),
    .sample_ready_i(sample_ready), .buffer_ready_o(buf_ready));

  // Monitor: a word leaves the buffer on an edge that sees valid and ready high.
  always @(posedge core_clk_i)
  begin
    if (valid_out_flag === 1'b1 && sample_ready === 1'b1)
    begin
      q_sin.push_back(quad);
      q_cos.push_back(inph);
      q_t.push_back($time);
    end
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // Tolerant compare, because the rotation generator leaves a few codes of error.
  task automatic near(input string name, input nco_sample_t exp, input nco_sample_t seen);
    logic signed [16:0] d;
    d = seen - exp;
    cmp_count++;
    if (^seen === 1'bx || d > 17'sd8 || d < -17'sd8)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // Takes the next popped pair under a bounded wait and compares both halves.
  task automatic take(input nco_sample_t es, input nco_sample_t ec);
    int i;
    i = 0;
    while (q_sin.size() == 0 && i < 80)
    begin
      @(posedge core_clk_i);
      #1;
      i++;
    end
    if (q_sin.size() == 0)
      check("sample_count", 1, 0);
    else
    begin
      near("quad_wave", es, q_sin.pop_front());
      near("inphase_wave", ec, q_cos.pop_front());
      t_pop = q_t.pop_front();
    end
  endtask

  task automatic end_sim();
    $display("Compares %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog: the tests need well under a thousand cycles.
  initial
  begin
    repeat (3000) @(posedge core_clk_i);
    n_mismatch++;
    end_sim();
  end

  initial
  begin
    nco_nsample_t_dummy_guard();
  end

  task automatic nco_nsample_t_dummy_guard();
    logic [15:0] ph [4];
    nco_sample_t es [4];
    nco_sample_t ec [4];
    ph = '{16'h0000, 16'h4000, 16'h8000, 16'hC000};
    es = '{Z, P, Z, N};
    ec = '{P, Z, N, Z};
    rst_i = 1'b1;
    sample_ready = 1'b1;
    oes_n = 1'b0;
    oec_n = 1'b0;
    repeat (20) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    #1;
    check("valid_out_flag", 0, valid_out_flag);
    // Each drive enable must reach its own bus enable, and only that one.
    oes_n <= 1'b1;
    @(posedge core_clk_i);
    #1;
    check("quad_wave_oe_n", 1, oes_seen);
    check("inphase_wave_oe_n", 0, oec_seen);
    oes_n <= 1'b0;
    oec_n <= 1'b1;
    @(posedge core_clk_i);
    #1;
    check("quad_wave_oe_n", 0, oes_seen);
    check("inphase_wave_oe_n", 1, oec_seen);
    oec_n <= 1'b0;
    // Jumps to the four quadrants; each result must pop one cycle after it shows.
    for (int k = 0; k < 4; k++)
    begin
      nco_src_inst.send({ph[k], 18'h0}, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
      t_in = $time;
      nco_src_inst.idle();
      take(es[k], ec[k]);
      check("latency", `NCO_RESULT_LAT + 1, (t_pop - t_in) / 25);
    end
    $display("jump test done");
    // Clear, then a new increment each cycle, a wrap, and a held word on the last.
    nco_src_inst.send('0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    nco_src_inst.send(Q, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    nco_src_inst.send(Q, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    nco_src_inst.send('0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    nco_src_inst.send(2 * Q, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    nco_src_inst.send('1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    nco_src_inst.idle();
    take(P, Z);
    take(Z, N);
    take(Z, N);
    take(Z, P);
    take(Z, N);
    $display("frequency test done");
    // Scaling: half and minus one, then full increment load, then short increment.
    nco_src_inst.send('0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    nco_src_inst.send({16'h4000, 18'h0}, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    nco_src_inst.send({16'h8000, 18'h0}, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    nco_src_inst.send(Q, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
    nco_src_inst.send({16'h4000, 18'h0}, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    nco_src_inst.idle();
    take(Z, H);
    take(Z, N);
    take(H, Z);
    take(Z, HN);
    $display("scaling test done");
    // Fill the buffer with the sink stalled, then drain it.
    sample_ready <= 1'b0;
    for (int k = 0; k < 10; k++)
      nco_src_inst.send('0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    nco_src_inst.idle();
    repeat (40) @(posedge core_clk_i);
    #1;
    check("buffer_ready", 0, buf_ready);
    check("valid_out_flag", 1, valid_out_flag);
    sample_ready <= 1'b1;
    repeat (12) @(posedge core_clk_i);
    #1;
    check("drained_words", `NCO_FIFO_DEPTH, q_sin.size());
    check("valid_out_flag", 0, valid_out_flag);
    check("buffer_ready", 1, buf_ready);
    $display("buffer test done");
    end_sim();
  endtask

endmodule
